/* File: verilog/power_mode_cfg.svh */
`ifndef POWER_MODE_CFG_SVH
`define POWER_MODE_CFG_SVH

// ==========================================
// Widths
`define PORTA_W        8
`define CAUSE_W        4

// ==========================================
// Register byte offsets
`define OFF_CTL        8'h00
`define OFF_OSC        8'h04
`define OFF_STAT       8'h08
`define OFF_WAKE_EN    8'h0C
`define OFF_CAUSE      8'h10

// ==========================================
// Clock control register fields
`define CTL_SEL        7:5
`define CTL_FAST_SRC   3
`define CTL_SLOW_SRC   2
`define CTL_HI_IDLE    1
`define CTL_LO_IDLE    0
`define CTL_RST        8'h00
`define CTL_WMASK      8'hEF
`define SEL_SLOW       3'h7

// ==========================================
// Oscillator register fields
`define OSC_EN         2:0
`define OSC_FREQ       4:3
`define OSC_STABLE     10:8
`define OSC_EN_RST     3'h1
`define FREQ_RST       2'h0
`define OSC_INT_FAST   0
`define OSC_EXT_FAST   1
`define OSC_EXT_SLOW   2

// ==========================================
// Status register fields
`define STAT_PWRDN     0
`define STAT_EXPIRED   1
`define STAT_SLOW      2
`define STAT_BUSY      3

// ==========================================
// Wake cause bits
`define CAUSE_IRQ      0
`define CAUSE_PA       1
`define CAUSE_WDT      2
`define CAUSE_CLR      3

// ==========================================
// Timing counts in pclk cycles
`define SW_HOLD_CYC    4
`define SLOW_TICK_CYC  1220

`endif

/* File: verilog/power_mode_pkg.sv */
`default_nettype none
`include "power_mode_cfg.svh"

package power_mode_pkg;

	typedef enum logic [5:0] {
		ST_RUN       = 6'h01,
		ST_SLEEP     = 6'h02,
		ST_IDLE_SLOW = 6'h04,
		ST_IDLE_BOTH = 6'h08,
		ST_IDLE_FAST = 6'h10,
		ST_WAKE      = 6'h20
	} pm_state_e;

	typedef struct packed {
		logic                clear_pin_n;
		logic                wdt_overflow;
		logic [`PORTA_W-1:0] port_a;
		logic [`PORTA_W-1:0] irq_req;
		logic [`PORTA_W-1:0] irq_en;
		logic                stack_full;
	} wake_in_s;

	typedef struct packed {
		logic       cpu_clk_en;
		logic       fast_clk_en;
		logic       slow_clk_en;
		logic       wdt_clk_en;
		logic [2:0] sysclk_sel;
		logic       fast_src;
		logic       slow_src;
		logic       div_tick;
	} clk_ctl_s;

	typedef struct packed {
		logic full_reset;
		logic wdt_reset;
		logic resume_next;
		logic irq_service;
		logic wdt_clear;
	} cpu_evt_s;

endpackage

`default_nettype wire

/* File: verilog/sync2.sv */
`timescale 1ns/1ps
`default_nettype none

module sync2 #(
	parameter int           W   = 1,
	parameter logic [W-1:0] RST = '0
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// Data
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= RST;
			q      <= RST;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end

endmodule // sync2

`default_nettype wire

/* File: verilog/sysclk_switch.sv */
`timescale 1ns/1ps
`default_nettype none
`include "power_mode_cfg.svh"

module sysclk_switch (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// Request
	input  wire logic [2:0] req_sel,
	input  wire logic       fast_ok,
	input  wire logic       slow_ok,
	// Active selection
	output logic      [2:0] sel_q,
	output logic            gate_q,
	output logic            tick_q,
	output logic            busy_q
);

	logic [2:0]  hold_q;
	logic [5:0]  div_q;
	logic [10:0] slow_cnt_q;

	// ==========================================
	// Switch decode
	wire logic       target_ok = (req_sel == `SEL_SLOW) ? slow_ok : fast_ok;
	wire logic       change    = req_sel != sel_q;
	wire logic       go        = change & target_ok;
	wire logic       last      = hold_q == 3'(`SW_HOLD_CYC - 1);
	wire logic [5:0] mask      = ~(6'h3F << sel_q);
	wire logic       slow_wrap = slow_cnt_q == 11'(`SLOW_TICK_CYC - 1);

	// ==========================================
	// Gate off, swap source, gate on
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sel_q      <= 3'h0;
			gate_q     <= 1'b1;
			tick_q     <= 1'b0;
			busy_q     <= 1'b0;
			hold_q     <= 3'h0;
			div_q      <= 6'h00;
			slow_cnt_q <= 11'h000;
		end else begin
			busy_q     <= change;
			gate_q     <= ~go;
			hold_q     <= (go & ~last) ? hold_q + 3'h1 : 3'h0;
			if (go & last) begin
				sel_q <= req_sel;
			end
			div_q      <= div_q + 6'h01;
			slow_cnt_q <= slow_wrap ? 11'h000 : slow_cnt_q + 11'h001;
			tick_q     <= (sel_q == `SEL_SLOW) ? slow_wrap : ((div_q & mask) == 6'h00);
		end
	end

endmodule // sysclk_switch

`default_nettype wire

/* File: verilog/power_mode_wakeup_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
`include "power_mode_cfg.svh"

// ==========================================
// Summary of operation
// - Select field 111 in fast mode moves the system clock to the slow clock.
// - Slow clock comes from slow crystal or internal slow oscillator; must be stable.
// - Select field 000 to 110 returns to fast clock divided by 1 to 64.
// - Fast clock turned off in slow mode is used again only once stable.
// - Stop with both idle bits 0 enters sleep; only the watchdog keeps running. Here any enabled oscillator that is not the selected source stays on.
// - Stop with high 0, low 1 enters idle with slow clock only.
// - Stop with both idle bits 1 enters idle with both clocks running.
// - Stop with high 1, low 0 enters idle with fast clock only.
// - Low-power entry halts the program and keeps memory, registers and ports.
// - Low-power entry sets the power-down flag and clears the timeout flag.
// - Low-power entry clears the watchdog, which then runs only if enabled.
// - Wake on clear pin, port A falling edge, interrupt or watchdog overflow.
// - Clear pin wake gives full reset; watchdog wake gives watchdog reset.
// - Watchdog timeout in low power sets timeout flag, resets only PC and SP.
// - Power-down flag cleared by power-up or clear-watchdog, set on stop.
// - Enabled port A falling edge wakes and resumes after the stop.
// - Disabled interrupt or full stack: resume after stop, service later.
// - Enabled interrupt with free stack: normal interrupt response.
// - An interrupt already pending at entry cannot wake the device.
// - Clock control register: select 7:5, fast src 3, slow src 2, idle bits 1:0.
// - Source bits: 0 picks internal oscillator, 1 picks external crystal.
// - Stable flag clears on enable or frequency change, sets once stable.

module power_mode_wakeup_ctrl (
	// Clock and reset
	input  wire logic                       pclk,
	input  wire logic                       presetn,
	// APB slave
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [7:0]                 paddr,
	input  wire logic [31:0]                pwdata,
	output logic      [31:0]                prdata,
	output logic                            pready,
	output logic                            pslverr,
	// CPU core
	input  wire logic                       stop_exec,
	input  wire logic                       clr_wdt_exec,
	output logic                            cpu_halt,
	output power_mode_pkg::cpu_evt_s        cpu_evt,
	// Watchdog and wake sources
	input  wire logic                       wdt_enable,
	input  wire power_mode_pkg::wake_in_s   wake_in,
	// Oscillators
	input  wire logic [2:0]                 osc_ready,
	input  wire logic                       int_slow_ready,
	output logic      [2:0]                 osc_on,
	output power_mode_pkg::clk_ctl_s        clk_ctl
);

	import power_mode_pkg::*;

	// ==========================================
	// State
	pm_state_e           state_q;
	pm_state_e           state_d;
	pm_state_e           lp_target;
	logic [7:0]          system_clock_ctrl_reg_q;
	logic [2:0]          osc_en_q;
	logic [1:0]          int_fast_freq_q;
	logic [2:0]          stable_q;
	logic                power_down_flag_q;
	logic                watchdog_expired_flag_q;
	logic [`PORTA_W-1:0] port_a_wake_enable_q;
	logic [`PORTA_W-1:0] irq_mask_q;
	logic [`PORTA_W-1:0] porta_prev_q;
	logic [`CAUSE_W-1:0] cause_q;
	logic                serve_q;
	logic [2:0]          on_d;
	logic [2:0]          restart;
	logic [`PORTA_W:0]   pin_s;
	logic [2:0]          act_sel;
	logic                sw_gate;
	logic                sw_tick;
	logic                sw_busy;

	// ==========================================
	// Register fields
	wire logic [2:0] sysclk_select_field = system_clock_ctrl_reg_q[`CTL_SEL];
	wire logic       fast_source_select  = system_clock_ctrl_reg_q[`CTL_FAST_SRC];
	wire logic       slow_source_select  = system_clock_ctrl_reg_q[`CTL_SLOW_SRC];
	wire logic       high_idle_enable    = system_clock_ctrl_reg_q[`CTL_HI_IDLE];
	wire logic       low_idle_enable     = system_clock_ctrl_reg_q[`CTL_LO_IDLE];

	// ==========================================
	// APB decode
	wire logic setup     = psel & ~penable;
	wire logic wr        = psel & penable & pwrite & pready;
	wire logic hit_ctl   = paddr == `OFF_CTL;
	wire logic hit_osc   = paddr == `OFF_OSC;
	wire logic hit_stat  = paddr == `OFF_STAT;
	wire logic hit_wake  = paddr == `OFF_WAKE_EN;
	wire logic hit_cause = paddr == `OFF_CAUSE;
	wire logic mapped    = hit_ctl | hit_osc | hit_stat | hit_wake | hit_cause;
	wire logic wr_ctl    = wr & hit_ctl;
	wire logic wr_osc    = wr & hit_osc;
	wire logic wr_wake   = wr & hit_wake;
	wire logic freq_chg  = wr_osc & (pwdata[`OSC_FREQ] != int_fast_freq_q);

	wire logic [31:0] rd_ctl   = {24'h000000, system_clock_ctrl_reg_q};
	wire logic [31:0] rd_osc   = {21'h000000, stable_q, 3'h0, int_fast_freq_q, osc_en_q};
	wire logic [31:0] rd_stat  = {28'h0000000, sw_busy, act_sel == `SEL_SLOW,
		watchdog_expired_flag_q, power_down_flag_q};
	wire logic [31:0] rd_wake  = {{(32-`PORTA_W){1'b0}}, port_a_wake_enable_q};
	wire logic [31:0] rd_cause = {{(32-`CAUSE_W){1'b0}}, cause_q};
	wire logic [31:0] rd_word  = hit_ctl ? rd_ctl :
		hit_osc ? rd_osc :
		hit_stat ? rd_stat :
		hit_wake ? rd_wake :
		hit_cause ? rd_cause : 32'h00000000;

	// ==========================================
	// Oscillator selection and readiness
	wire logic fast_ok = fast_source_select ? stable_q[`OSC_EXT_FAST] : stable_q[`OSC_INT_FAST];
	wire logic slow_ok = slow_source_select ? stable_q[`OSC_EXT_SLOW] : int_slow_ready;
	wire logic slow_on = act_sel == `SEL_SLOW;
	wire logic cur_ok  = slow_on ? slow_ok : fast_ok;

	// ==========================================
	// Mode decode
	wire logic in_run   = state_q == ST_RUN;
	wire logic in_wake  = state_q == ST_WAKE;
	wire logic in_lp    = ~in_run & ~in_wake;
	wire logic entry    = in_run & stop_exec;
	wire logic fast_need = (in_run & ~(slow_on & sysclk_select_field == `SEL_SLOW)) |
		(in_wake & ~slow_on) | (state_q == ST_IDLE_BOTH) | (state_q == ST_IDLE_FAST);
	wire logic slow_need = in_run | in_wake | (state_q == ST_IDLE_SLOW) |
		(state_q == ST_IDLE_BOTH);

	assign lp_target = !high_idle_enable ?
		(!low_idle_enable ? ST_SLEEP : ST_IDLE_SLOW) :
		(low_idle_enable ? ST_IDLE_BOTH : ST_IDLE_FAST);

	// ==========================================
	// Wake sources
	wire logic                clr_s    = pin_s[`PORTA_W];
	wire logic [`PORTA_W-1:0] porta_s  = pin_s[`PORTA_W-1:0];
	wire logic [`PORTA_W-1:0] pa_fall  = porta_prev_q & ~porta_s & port_a_wake_enable_q;
	wire logic [`PORTA_W-1:0] new_irq  = wake_in.irq_req & ~irq_mask_q;
	wire logic                clr_wake = ~clr_s;
	wire logic                wdt_wake = wake_in.wdt_overflow;
	wire logic                pa_wake  = |pa_fall;
	wire logic                irq_wake = |new_irq;
	wire logic                any_wake = clr_wake | wdt_wake | pa_wake | irq_wake;
	wire logic                wake_now = in_lp & any_wake;
	wire logic                serve_d  = |(new_irq & wake_in.irq_en) & ~wake_in.stack_full;
	wire logic                rst_cause = cause_q[`CAUSE_CLR] | cause_q[`CAUSE_WDT];
	wire logic                leave    = in_wake & (rst_cause | cur_ok);

	wire logic [`CAUSE_W-1:0] cause_d = clr_wake ? 4'h8 :
		wdt_wake ? 4'h4 :
		pa_wake ? 4'h2 : 4'h1;

	// ==========================================
	// Oscillator enables
	assign on_d[`OSC_INT_FAST] = osc_en_q[`OSC_INT_FAST] & (fast_need | fast_source_select);
	assign on_d[`OSC_EXT_FAST] = osc_en_q[`OSC_EXT_FAST] & (fast_need | ~fast_source_select);
	assign on_d[`OSC_EXT_SLOW] = osc_en_q[`OSC_EXT_SLOW] & (slow_need | ~slow_source_select);
	assign restart = (on_d & ~osc_on) | {2'b00, freq_chg};

	// ==========================================
	// Pin synchroniser and clock switch
	sync2 #(
		.W   (`PORTA_W + 1),
		.RST ({(`PORTA_W + 1){1'b1}})
	) u_pin_sync (
		.clk   (pclk),
		.rst_n (presetn),
		.d     ({wake_in.clear_pin_n, wake_in.port_a}),
		.q     (pin_s)
	);

	sysclk_switch u_switch (
		.clk     (pclk),
		.rst_n   (presetn),
		.req_sel (sysclk_select_field),
		.fast_ok (fast_ok),
		.slow_ok (slow_ok),
		.sel_q   (act_sel),
		.gate_q  (sw_gate),
		.tick_q  (sw_tick),
		.busy_q  (sw_busy)
	);

	// ==========================================
	// Power mode state machine
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_RUN: begin
				if (stop_exec) begin
					state_d = lp_target;
				end
			end
			ST_SLEEP, ST_IDLE_SLOW, ST_IDLE_BOTH, ST_IDLE_FAST: begin
				if (any_wake) begin
					state_d = ST_WAKE;
				end
			end
			ST_WAKE: begin
				if (leave) begin
					state_d = ST_RUN;
				end
			end
			default: begin
				state_d = ST_RUN;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= ST_RUN;
		end else begin
			state_q <= state_d;
		end
	end

	// ==========================================
	// APB slave
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end else begin
			pready  <= setup;
			pslverr <= setup & ~mapped;
			prdata  <= (setup & ~pwrite) ? rd_word : 32'h00000000;
		end
	end

	// ==========================================
	// Software registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			system_clock_ctrl_reg_q <= `CTL_RST;
			osc_en_q                <= `OSC_EN_RST;
			int_fast_freq_q         <= `FREQ_RST;
			port_a_wake_enable_q    <= {`PORTA_W{1'b0}};
		end else begin
			if (wr_ctl) begin
				system_clock_ctrl_reg_q <= pwdata[7:0] & `CTL_WMASK;
			end
			if (wr_osc) begin
				osc_en_q        <= pwdata[`OSC_EN];
				int_fast_freq_q <= pwdata[`OSC_FREQ];
			end
			if (wr_wake) begin
				port_a_wake_enable_q <= pwdata[`PORTA_W-1:0];
			end
		end
	end

	// ==========================================
	// Oscillator stable flags
	for (genvar i = 0; i < 3; i++) begin : g_stable
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				stable_q[i] <= 1'b0;
			end else if (restart[i] | ~osc_on[i]) begin
				stable_q[i] <= 1'b0;
			end else if (osc_ready[i]) begin
				stable_q[i] <= 1'b1;
			end
		end
	end

	// ==========================================
	// Status flags
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			power_down_flag_q       <= 1'b0;
			watchdog_expired_flag_q <= 1'b0;
		end else begin
			power_down_flag_q       <= entry | (power_down_flag_q & ~clr_wdt_exec);
			watchdog_expired_flag_q <= wdt_wake | (watchdog_expired_flag_q & ~entry);
		end
	end

	// ==========================================
	// Wake bookkeeping
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_mask_q   <= {`PORTA_W{1'b0}};
			porta_prev_q <= {`PORTA_W{1'b1}};
			cause_q      <= {`CAUSE_W{1'b0}};
			serve_q      <= 1'b0;
		end else begin
			porta_prev_q <= porta_s;
			if (entry) begin
				irq_mask_q <= wake_in.irq_req;
			end
			if (wake_now) begin
				cause_q <= cause_d;
				serve_q <= serve_d;
			end
		end
	end

	// ==========================================
	// CPU events
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cpu_evt  <= '0;
			cpu_halt <= 1'b0;
		end else begin
			cpu_halt              <= state_d != ST_RUN;
			cpu_evt.full_reset    <= (wake_now & clr_wake) | (in_run & wdt_wake);
			cpu_evt.wdt_reset     <= wake_now & ~clr_wake & wdt_wake;
			cpu_evt.resume_next   <= leave & (cause_q[`CAUSE_PA] |
				(cause_q[`CAUSE_IRQ] & ~serve_q));
			cpu_evt.irq_service   <= leave & cause_q[`CAUSE_IRQ] & serve_q;
			cpu_evt.wdt_clear     <= entry | clr_wdt_exec;
		end
	end

	// ==========================================
	// Clock enables to the rest of the chip
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			osc_on  <= 3'h0;
			clk_ctl <= '0;
		end else begin
			osc_on              <= on_d;
			clk_ctl.cpu_clk_en  <= (state_d == ST_RUN) & sw_gate & cur_ok;
			clk_ctl.fast_clk_en <= fast_need & fast_ok;
			clk_ctl.slow_clk_en <= slow_need & slow_ok;
			clk_ctl.wdt_clk_en  <= wdt_enable;
			clk_ctl.sysclk_sel  <= act_sel;
			clk_ctl.fast_src    <= fast_source_select;
			clk_ctl.slow_src    <= slow_source_select;
			clk_ctl.div_tick    <= sw_tick & sw_gate;
		end
	end

endmodule // power_mode_wakeup_ctrl

`default_nettype wire

/* File: test/osc_model.sv */
`timescale 1ns/1ps
`default_nettype none

module osc_model #(
	parameter int SETTLE = 16
) (
	// Clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// Oscillator enables and ready levels
	input  wire logic [2:0] osc_on,
	output logic      [2:0] osc_ready,
	output logic            int_slow_ready
);
	// ==========================================
	// Oscillators settle SETTLE cycles after enable
	for (genvar i = 0; i < 3; i++) begin : g_osc
		int cnt_q;
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn)
				cnt_q <= 0;
			else if (!osc_on[i])
				cnt_q <= 0;
			else if (cnt_q < SETTLE)
				cnt_q <= cnt_q + 1;
		end
		assign osc_ready[i] = (cnt_q == SETTLE);
	end
	// Internal slow oscillator always runs
	assign int_slow_ready = presetn;
endmodule // osc_model

`default_nettype wire

/* File: test/power_mode_checker.sv */
`timescale 1ns/1ps
`default_nettype none
`include "power_mode_cfg.svh"

module power_mode_checker (
	// Clock and reset
	input wire logic                     pclk,
	input wire logic                     presetn,
	// APB
	input wire logic                     psel,
	input wire logic                     penable,
	input wire logic                     pwrite,
	input wire logic [7:0]               paddr,
	input wire logic [31:0]              pwdata,
	input wire logic [31:0]              prdata,
	input wire logic                     pready,
	input wire logic                     pslverr,
	// CPU, wake sources and clocks
	input wire logic                     stop_exec,
	input wire logic                     cpu_halt,
	input wire power_mode_pkg::cpu_evt_s cpu_evt,
	input wire power_mode_pkg::wake_in_s wake_in,
	input wire logic [2:0]               osc_ready,
	input wire logic                     int_slow_ready,
	input wire power_mode_pkg::clk_ctl_s clk_ctl
);
	import power_mode_pkg::*;
	logic [1:0]      idle_q;
	logic [7:0]      wen_q;
	logic [7:0]      pa_q;
	wire logic       apb_wr  = psel && penable && pready && pwrite;
	wire logic [7:0] pa_fell = pa_q & ~wake_in.port_a & wen_q;

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	// ==========================================
	// Shadow of idle bits, wake enables and pins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			idle_q <= 2'h0;
			wen_q  <= 8'h00;
			pa_q   <= 8'hFF;
		end else begin
			pa_q <= wake_in.port_a;
			if (apb_wr && paddr == `OFF_CTL)
				idle_q <= pwdata[1:0];
			if (apb_wr && paddr == `OFF_WAKE_EN)
				wen_q <= pwdata[7:0];
		end
	end

	// ==========================================
	// Sequences and properties
	sequence stop_taken;
		stop_exec && !cpu_halt;
	endsequence
	sequence wake_resumed;
		cpu_evt.resume_next || cpu_evt.irq_service;
	endsequence
	property mode_clk(logic [1:0] m, logic f, logic s);
		stop_taken ##0 (idle_q == m && clk_ctl.sysclk_sel != `SEL_SLOW)
			|-> ##[1:4] (clk_ctl.fast_clk_en == f && clk_ctl.slow_clk_en == s);
	endproperty

	// ==========================================
	// Assertions
	AST_STOP_HALT: assert property (stop_taken |=> cpu_halt && cpu_evt.wdt_clear)
		else $error("stop did not halt and clear the watchdog");
	AST_SLEEP_CLK: assert property (mode_clk(2'b00, 1'b0, 1'b0))
		else $error("sleep clocks wrong");
	AST_IDLE_SLOW: assert property (mode_clk(2'b01, 1'b0, 1'b1))
		else $error("slow-only idle clocks wrong");
	AST_IDLE_BOTH: assert property (mode_clk(2'b11, 1'b1, 1'b1))
		else $error("two-clock idle clocks wrong");
	AST_IDLE_FAST: assert property (mode_clk(2'b10, 1'b1, 1'b0))
		else $error("fast-only idle clocks wrong");
	AST_APB_READY: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	AST_APB_UNMAP: assert property (psel && penable && pready && (paddr > `OFF_CAUSE || paddr[1:0] != 2'b00)
		|-> pslverr && prdata == 32'h0) else $error("unmapped access not refused");
	AST_WDT_WAKE: assert property (cpu_halt && wake_in.wdt_overflow && wake_in.clear_pin_n
		|=> cpu_evt.wdt_reset && !cpu_evt.full_reset) else $error("watchdog wake wrong");
	AST_CLR_WAKE: assert property (cpu_halt && $fell(wake_in.clear_pin_n) |-> ##[1:6] cpu_evt.full_reset)
		else $error("clear pin wake missing");
	AST_PA_WAKE: assert property (cpu_halt && pa_fell != 8'h00 |-> ##[1:80] wake_resumed)
		else $error("port wake missing");
	AST_FAST_SWAP: assert property ($changed(clk_ctl.sysclk_sel) && clk_ctl.sysclk_sel != `SEL_SLOW
		|-> osc_ready[clk_ctl.fast_src]) else $error("fast clock used before stable");
	AST_SLOW_SWAP: assert property ($changed(clk_ctl.sysclk_sel) && clk_ctl.sysclk_sel == `SEL_SLOW
		|-> (clk_ctl.slow_src ? osc_ready[2] : int_slow_ready)) else $error("slow clock used before stable");
endmodule // power_mode_checker

bind power_mode_wakeup_ctrl power_mode_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .stop_exec(stop_exec), .cpu_halt(cpu_halt), .cpu_evt(cpu_evt), .wake_in(wake_in),
	.osc_ready(osc_ready), .int_slow_ready(int_slow_ready), .clk_ctl(clk_ctl));

`default_nettype wire

/* File: test/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "power_mode_cfg.svh"

module testbench;
	import power_mode_pkg::*;
	typedef struct packed {logic [7:0] ctl; logic wdt; logic fast; logic slow;} row_s;
	localparam row_s ROWS [4] = '{'{8'h00, 1'b0, 1'b0, 1'b0}, '{8'h01, 1'b1, 1'b0, 1'b1},
		'{8'h02, 1'b0, 1'b1, 1'b0}, '{8'h03, 1'b1, 1'b1, 1'b1}};
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic        stop_exec, clr_wdt_exec, wdt_enable, cpu_halt, int_slow_ready;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [2:0]  osc_ready, osc_on, tgt;
	wake_in_s    wk;
	cpu_evt_s    cpu_evt;
	clk_ctl_s    clk_ctl;
	int          err_total = 0;
	int          cmp_count = 0;
	int          cyc = 0;
	int          cnt;

	power_mode_wakeup_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .stop_exec(stop_exec), .clr_wdt_exec(clr_wdt_exec), .cpu_halt(cpu_halt),
		.cpu_evt(cpu_evt), .wdt_enable(wdt_enable), .wake_in(wk), .osc_ready(osc_ready),
		.int_slow_ready(int_slow_ready), .osc_on(osc_on), .clk_ctl(clk_ctl));
	osc_model #(.SETTLE(16)) u_osc (.pclk(pclk), .presetn(presetn), .osc_on(osc_on),
		.osc_ready(osc_ready), .int_slow_ready(int_slow_ready));

	// ==========================================
	// Helpers
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	function automatic logic ev(input int k);
		case (k)
			0: return cpu_evt.resume_next;
			1: return cpu_evt.irq_service;
			2: return cpu_evt.wdt_reset;
			3: return cpu_evt.full_reset;
			4: return clk_ctl.sysclk_sel === tgt;
			default: return clk_ctl.fast_src & clk_ctl.cpu_clk_en;
		endcase
	endfunction
	task automatic wait_ev(input int k);
		int n;
		n = 0;
		do begin @(posedge pclk); n++; end while (ev(k) !== 1'b1 && n < 8000);
		chk(32'(n < 8000), 32'h1);
	endtask
	task automatic stop();
		stop_exec <= 1'b1;
		@(posedge pclk);
		stop_exec <= 1'b0;
	endtask

	// ==========================================
	// Clock and timeout
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			err_total++;
			print_verdict();
		end
	end

	// ==========================================
	// Main sequence
	initial begin
		{presetn, psel, penable, pwrite, stop_exec, clr_wdt_exec, wdt_enable} = '0;
		paddr = 8'h00;
		pwdata = 32'h0;
		tgt = 3'h0;
		wk = '0;
		wk.clear_pin_n = 1'b1;
		wk.port_a = 8'hFF;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(0, `OFF_CTL, 0); chk(rd, 32'h0);
		apb(0, `OFF_STAT, 0); chk(rd & 32'h3, 32'h0);
		apb(0, `OFF_OSC, 0); chk(rd & 32'h1F, 32'h1);
		apb(1, `OFF_CTL, 32'h13); apb(0, `OFF_CTL, 0); chk(rd, 32'h3);
		apb(0, 8'h14, 0); chk({er, rd[30:0]}, 32'h80000000);
		apb(1, `OFF_WAKE_EN, 32'h01);
		for (int i = 0; i < 4; i++) begin
			wdt_enable <= ROWS[i].wdt;
			apb(1, `OFF_CTL, {24'h0, ROWS[i].ctl});
			stop();
			repeat (3) @(posedge pclk);
			chk(32'({cpu_halt, clk_ctl.cpu_clk_en, clk_ctl.fast_clk_en, clk_ctl.slow_clk_en, clk_ctl.wdt_clk_en}),
				32'({2'b10, ROWS[i].fast, ROWS[i].slow, ROWS[i].wdt}));
			chk(32'(osc_on), {31'h0, ROWS[i].fast});
			apb(0, `OFF_STAT, 0); chk(rd & 32'h3, 32'h1);
			wk.port_a[1] <= 1'b0;
			repeat (10) @(posedge pclk);
			chk(32'(cpu_halt), 32'h1);
			wk.port_a[0] <= 1'b0;
			wait_ev(0);
			wk.port_a <= 8'hFF;
			repeat (2) @(posedge pclk);
		end
		// Pending request cannot wake; a new enabled one is serviced
		wk.irq_req <= 8'h02;
		wk.irq_en <= 8'h06;
		@(posedge pclk);
		stop();
		repeat (20) @(posedge pclk);
		chk(32'(cpu_halt), 32'h1);
		wk.irq_req <= 8'h06;
		wait_ev(1);
		for (int i = 0; i < 2; i++) begin
			wk.irq_req <= 8'h00;
			wk.irq_en <= i[0] ? 8'h04 : 8'h00;
			wk.stack_full <= i[0];
			@(posedge pclk);
			stop();
			repeat (3) @(posedge pclk);
			wk.irq_req <= 8'h04;
			wait_ev(0);
		end
		wk.irq_req <= 8'h00;
		wk.stack_full <= 1'b0;
		// Watchdog wake, then clear-watchdog instruction
		stop();
		repeat (3) @(posedge pclk);
		wk.wdt_overflow <= 1'b1;
		@(posedge pclk);
		wk.wdt_overflow <= 1'b0;
		wait_ev(2);
		apb(0, `OFF_STAT, 0); chk(rd & 32'h3, 32'h3);
		clr_wdt_exec <= 1'b1;
		@(posedge pclk);
		clr_wdt_exec <= 1'b0;
		apb(0, `OFF_STAT, 0); chk(rd & 32'h1, 32'h0);
		// Clear pin wake
		stop();
		repeat (3) @(posedge pclk);
		wk.clear_pin_n <= 1'b0;
		wait_ev(3);
		wk.clear_pin_n <= 1'b1;
		repeat (5) @(posedge pclk);
		// External fast crystal as fast source
		apb(1, `OFF_OSC, 32'h7);
		apb(0, `OFF_OSC, 0); chk(rd & 32'h200, 32'h0);
		apb(1, `OFF_CTL, 32'h08);
		wait_ev(5);
		apb(0, `OFF_OSC, 0); chk(rd & 32'h200, 32'h200);
		// Slow mode and back to every divided fast clock
		for (int s = 0; s < 7; s++) begin
			tgt = 3'h7;
			apb(1, `OFF_CTL, {24'h0, 5'h1C, s[0], 2'h0});
			wait_ev(4);
			chk(32'(clk_ctl.slow_src), 32'(s[0]));
			tgt = s[2:0];
			apb(1, `OFF_CTL, {24'h0, s[2:0], 5'h0});
			wait_ev(4);
			chk(32'(osc_ready[0]), 32'h1);
			cnt = 0;
			repeat (128) begin @(posedge pclk); cnt += int'(clk_ctl.div_tick); end
			chk(32'(cnt), 32'(128 >> s));
		end
		print_verdict();
	end
endmodule // testbench

`default_nettype wire
